//--- power_mode_clock_control.v
// Power mode, clock source, synthesizer, watchdog lock and RAM power control
// Functional notes
// - After reset the main clock runs from the 12 MHz free-running oscillator.
// - Fast oscillator selects 48 or 60 MHz and may drive main clock.
// - System synthesizer locks about 150 us after enable; unusable before.
// - System reference 32.768 kHz..25 MHz; audio reference 1..25 MHz.
// - Each synthesizer has its own software on/off control.
// - Once watchdog is enabled its configuration ignores writes until reset.
// - Peripheral clocks adjustable; each RAM partition retained or powered off.
// - Each processor has its own sleep control.
// - Sleep gates processor clock until reset or interrupt, then resumes.
// - Clocked peripherals keep running in sleep and may wake processor.
// - Sleep and deep-sleep keep state, RAM and pin levels.
// - Deep-sleep gates main clock and all peripheral clocks.
// - Deep-sleep turns primary clock sources off unless software keeps them.
// - Deep-sleep powers analog blocks down unless software keeps them.
// - Deep-sleep always stops synthesizers and main clock; oscillators optional.
// - Pin interrupts and chosen peripherals may wake from deep-sleep.
// - Deep power-down removes all power except always-on domain and pins.
// - Deep power-down ends on reset pin, alarm or power manager pin.
// - The one-hertz alarm flag raises a wake-up request.
// - Deep power-down loses RAM and registers; functional pins float.
`timescale 1ns/1ps
`include "pmc_defs.vh"
module power_mode_clock_control #(
  parameter [31:0] EXT_CLK_HZ = 32'd25000000
) (
  // Clock and reset
  input wire clk_sys,
  input wire resetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // Processor handshakes
  input wire [1:0] cpuWfi,
  input wire [1:0] cpuIrq,
  // Wake sources
  input wire [7:0] wakeReq,
  input wire one_hz_alarm_flag,
  input wire power_manager_irq_pin_n,
  // Clock control
  output reg [2:0] mainClkSel,
  output reg fastOsc60,
  output reg mainClkEn,
  output reg [1:0] cpuClkEn,
  output reg [31:0] periphClkEn,
  output reg [5:0] oscEn,
  output reg sysSynthEn,
  output reg sysSynthLocked,
  output reg audSynthEn,
  // Power control
  output reg [3:0] analogPwrEn,
  output reg [29:0] ramPowerOff,
  output reg corePowerEn,
  output reg coreResetN,
  output reg pinHighZ,
  output reg rtcWakeReq,
  // Watchdog configuration
  output reg wdogEnable,
  output reg [30:0] wdogCfg
);

////////////////////////////////////////////////////////////////////////////
// Constants and state
localparam [1:0] G_RUN = 2'h0;
localparam [1:0] G_DSLP = 2'h1;
localparam [1:0] G_DPD = 2'h2;
localparam [1:0] G_RST = 2'h3;
// Lock count fits in 12 bits at this clock; the cut is deliberate
localparam integer LOCK_CYC_I = `SYNTH_LOCK_US * `CLK_MHZ;
localparam [11:0] LOCK_CYC = LOCK_CYC_I[11:0];
reg [1:0] glob_r;
reg [1:0] glob_nxt;
reg [3:0] rstCnt_r;
reg [1:0] asleep_r;
reg [11:0] lockCnt_r;
reg [2:0] clkSrc_r;
reg fast60_r;
reg sysEn_r;
reg audEn_r;
reg [1:0] sysRef_r;
reg [1:0] audRef_r;
reg [3:0] ana_r;
reg wdEn_r;
reg [30:0] wdCfg_r;
reg [29:0] ramOff_r;
reg [31:0] pclk_r;
reg [1:0] mode0_r;
reg [1:0] mode1_r;
reg [5:0] oscKeep_r;
reg [3:0] anaKeep_r;
reg [7:0] wakeEn_r;
reg wrPend_r;
reg [7:0] wrAddr_r;
////////////////////////////////////////////////////////////////////////////
// Helpers
// Frequency of a synthesizer reference choice
function [31:0] refHz;
  input [1:0] sel;
  begin
    if (sel == `REF_FRO12)
      refHz = `HZ_FRO12;
    else if (sel == `REF_INT16)
      refHz = `HZ_INT16;
    else if (sel == `REF_SLOWXTAL)
      refHz = `HZ_SLOWXTAL;
    else
      refHz = EXT_CLK_HZ;
  end
endfunction
// Reference within a synthesizer's input range
function refOk;
  input [1:0] sel;
  input [31:0] minHz;
  begin
    refOk = (refHz(sel) >= minHz) && (refHz(sel) <= `REF_MAX_HZ);
  end
endfunction
wire sysRefOk = refOk(sysRef_r, `SYS_REF_MIN_HZ);
wire audRefOk = refOk(audRef_r, `AUD_REF_MIN_HZ);
wire run = (glob_r == G_RUN);
// Synthesizers only run in the run state with a legal reference
wire sysOn = run && sysEn_r && sysRefOk;
wire audOn = run && audEn_r && audRefOk;
wire sysLocked = sysOn && (lockCnt_r == LOCK_CYC);
// Core logic is reset after power-down, just like at power-up
wire coreRst = (glob_r == G_RST);
wire dsWake = (|(wakeReq & wakeEn_r)) || one_hz_alarm_flag ||
  !power_manager_irq_pin_n || (|cpuIrq);
wire dpdWake = one_hz_alarm_flag || !power_manager_irq_pin_n;
wire accept = hsel && htrans[1] && hready;
wire [31:0] statusWord = {21'h0, clkSrc_r, glob_r, asleep_r, wdEn_r,
  audRefOk, sysRefOk, sysLocked};
////////////////////////////////////////////////////////////////////////////
// Bus slave: zero wait states, OKAY only
assign hreadyout = 1'b1;
assign hresp = 1'b0;
// Address phase: latch writes, fetch read data
always @(posedge clk_sys or negedge resetn) begin
  if (!resetn) begin
    wrPend_r <= 1'b0;
    wrAddr_r <= 8'h00;
    hrdata <= `RV_ZERO;
  end else if (hready) begin
    wrPend_r <= accept && hwrite;
    wrAddr_r <= haddr[7:0];
    if (accept && !hwrite) begin
      if (haddr[7:0] == `A_CLKSEL)
        hrdata <= {28'h0, fast60_r, clkSrc_r};
      else if (haddr[7:0] == `A_SYNTH)
        hrdata <= {20'h0, ana_r, 2'h0, audRef_r, sysRef_r, audEn_r, sysEn_r};
      else if (haddr[7:0] == `A_STATUS)
        hrdata <= statusWord;
      else if (haddr[7:0] == `A_WDOG)
        hrdata <= {wdCfg_r, wdEn_r};
      else if (haddr[7:0] == `A_RAMOFF)
        hrdata <= {2'h0, ramOff_r};
      else if (haddr[7:0] == `A_PCLK)
        hrdata <= pclk_r;
      else if (haddr[7:0] == `A_LPCFG)
        hrdata <= {18'h0, anaKeep_r, oscKeep_r, mode1_r, mode0_r};
      else if (haddr[7:0] == `A_WAKEEN)
        hrdata <= {24'h0, wakeEn_r};
      else
        hrdata <= `RV_ZERO;
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// Software registers, data phase writes
// Cleared at power-up and again when leaving deep power-down
always @(posedge clk_sys or negedge resetn) begin
  if (!resetn) begin
    clkSrc_r <= `SRC_FRO12;
    fast60_r <= 1'b0;
    sysEn_r <= 1'b0;
    audEn_r <= 1'b0;
    sysRef_r <= `REF_FRO12;
    audRef_r <= `REF_FRO12;
    ana_r <= 4'h0;
    wdEn_r <= 1'b0;
    wdCfg_r <= 31'h0;
    ramOff_r <= `RV_RAMOFF;
    pclk_r <= `RV_PCLK;
    mode0_r <= `MODE_ACT;
    mode1_r <= `MODE_ACT;
    oscKeep_r <= 6'h0;
    anaKeep_r <= 4'h0;
    wakeEn_r <= 8'h00;
  end else if (coreRst) begin
    clkSrc_r <= `SRC_FRO12;
    fast60_r <= 1'b0;
    sysEn_r <= 1'b0;
    audEn_r <= 1'b0;
    sysRef_r <= `REF_FRO12;
    audRef_r <= `REF_FRO12;
    ana_r <= 4'h0;
    wdEn_r <= 1'b0;
    wdCfg_r <= 31'h0;
    ramOff_r <= `RV_RAMOFF;
    pclk_r <= `RV_PCLK;
    mode0_r <= `MODE_ACT;
    mode1_r <= `MODE_ACT;
    oscKeep_r <= 6'h0;
    anaKeep_r <= 4'h0;
    wakeEn_r <= 8'h00;
  end else if (wrPend_r) begin
    if (wrAddr_r == `A_CLKSEL) begin
      clkSrc_r <= hwdata[2:0];
      fast60_r <= hwdata[`F_FAST60];
    end else if (wrAddr_r == `A_SYNTH) begin
      sysEn_r <= hwdata[`F_SYSEN];
      audEn_r <= hwdata[`F_AUDEN];
      sysRef_r <= hwdata[`F_SYSREF +: 2];
      audRef_r <= hwdata[`F_AUDREF +: 2];
      ana_r <= hwdata[`F_ANA +: 4];
    end else if (wrAddr_r == `A_WDOG) begin
      // Enabled watchdog refuses every further change
      if (!wdEn_r) begin
        wdEn_r <= hwdata[`F_WDEN];
        wdCfg_r <= hwdata[31:1];
      end
    end else if (wrAddr_r == `A_RAMOFF) begin
      ramOff_r <= hwdata[29:0];
    end else if (wrAddr_r == `A_PCLK) begin
      pclk_r <= hwdata;
    end else if (wrAddr_r == `A_LPCFG) begin
      mode0_r <= hwdata[1:0];
      mode1_r <= hwdata[3:2];
      oscKeep_r <= hwdata[`F_OSCKEEP +: 6];
      anaKeep_r <= hwdata[`F_ANAKEEP +: 4];
    end else if (wrAddr_r == `A_WAKEEN) begin
      wakeEn_r <= hwdata[7:0];
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// Per-processor sleep
genvar gi;
generate
  for (gi = 0; gi < 2; gi = gi + 1) begin : g_cpu
    wire [1:0] mode = (gi == 0) ? mode0_r : mode1_r;
    // Idle-wait with a chosen mode puts only this processor to sleep
    always @(posedge clk_sys or negedge resetn) begin
      if (!resetn)
        asleep_r[gi] <= 1'b0;
      else if (coreRst || cpuIrq[gi])
        asleep_r[gi] <= 1'b0;
      else if (run && cpuWfi[gi] && (mode != `MODE_ACT))
        asleep_r[gi] <= 1'b1;
    end
  end
endgenerate
////////////////////////////////////////////////////////////////////////////
// Chip power state
// Deep modes need both processors idle; processor 0 picks the depth.
// A wake source still pending blocks entry, else the chip would bounce
// between run and deep-sleep while the processors stay asleep.
always @* begin
  glob_nxt = glob_r;
  case (glob_r)
    G_RUN: begin
      if (&asleep_r && !dsWake) begin
        if (mode0_r == `MODE_DPD)
          glob_nxt = G_DPD;
        else if (mode0_r == `MODE_DSLEEP)
          glob_nxt = G_DSLP;
      end
    end
    G_DSLP: begin
      if (dsWake)
        glob_nxt = G_RUN;
    end
    G_DPD: begin
      if (dpdWake)
        glob_nxt = G_RST;
    end
    default: begin
      if (rstCnt_r == `RST_CYCLES)
        glob_nxt = G_RUN;
    end
  endcase
end
always @(posedge clk_sys or negedge resetn) begin
  if (!resetn) begin
    glob_r <= G_RUN;
    rstCnt_r <= 4'h0;
  end else begin
    glob_r <= glob_nxt;
    rstCnt_r <= coreRst ? rstCnt_r + 4'h1 : 4'h0;
  end
end
// Lock timer restarts whenever the synthesizer is stopped
always @(posedge clk_sys or negedge resetn) begin
  if (!resetn)
    lockCnt_r <= 12'h000;
  else if (!sysOn)
    lockCnt_r <= 12'h000;
  else if (lockCnt_r != LOCK_CYC)
    lockCnt_r <= lockCnt_r + 12'h001;
end

////////////////////////////////////////////////////////////////////////////
// Registered control outputs
// Outputs follow state one cycle late so they never glitch
always @(posedge clk_sys or negedge resetn) begin
  if (!resetn) begin
    mainClkSel <= `SRC_FRO12;
    fastOsc60 <= 1'b0;
    mainClkEn <= 1'b1;
    cpuClkEn <= 2'h3;
    periphClkEn <= `RV_PCLK;
    oscEn <= 6'h3F;
    sysSynthEn <= 1'b0;
    sysSynthLocked <= 1'b0;
    audSynthEn <= 1'b0;
    analogPwrEn <= 4'h0;
    ramPowerOff <= `RV_RAMOFF;
    corePowerEn <= 1'b1;
    coreResetN <= 1'b1;
    pinHighZ <= 1'b0;
    rtcWakeReq <= 1'b0;
    wdogEnable <= 1'b0;
    wdogCfg <= 31'h0;
  end else begin
    // Unlocked synthesizer falls back to the default oscillator
    mainClkSel <= (clkSrc_r == `SRC_SYSSYN && !sysLocked) ?
      `SRC_FRO12 : clkSrc_r;
    fastOsc60 <= fast60_r;
    mainClkEn <= run;
    cpuClkEn <= run ? ~asleep_r : 2'h0;
    periphClkEn <= run ? pclk_r : `RV_ZERO;
    if (glob_r == G_DSLP)
      oscEn <= oscKeep_r;
    else if (glob_r == G_DPD)
      oscEn <= 6'h00;
    else
      oscEn <= 6'h3F;
    sysSynthEn <= sysOn;
    sysSynthLocked <= sysLocked;
    audSynthEn <= audOn;
    if (glob_r == G_DSLP)
      analogPwrEn <= ana_r & anaKeep_r;
    else
      analogPwrEn <= run ? ana_r : 4'h0;
    // RAM keeps its content in sleep and deep-sleep, lost in power-down
    ramPowerOff <= (glob_r == G_DPD) ? ~`RV_RAMOFF : ramOff_r;
    corePowerEn <= (glob_r != G_DPD);
    coreResetN <= !coreRst;
    pinHighZ <= (glob_r == G_DPD);
    rtcWakeReq <= one_hz_alarm_flag;
    wdogEnable <= wdEn_r;
    wdogCfg <= wdCfg_r;
  end
end
endmodule // power_mode_clock_control

//--- pmc_defs.vh
// Constants for the power mode and clock control block
`ifndef PMC_DEFS_VH
`define PMC_DEFS_VH
// Register byte offsets
`define A_CLKSEL 8'h00
`define A_SYNTH 8'h04
`define A_STATUS 8'h08
`define A_WDOG 8'h0C
`define A_RAMOFF 8'h10
`define A_PCLK 8'h14
`define A_LPCFG 8'h18
`define A_WAKEEN 8'h1C
// Main clock source codes
`define SRC_FRO12 3'h0
`define SRC_FAST 3'h1
`define SRC_LP1M 3'h2
`define SRC_SLOWXTAL 3'h3
`define SRC_SYSSYN 3'h4
// Synthesizer reference codes and frequencies in Hz
`define REF_FRO12 2'h0
`define REF_INT16 2'h1
`define REF_SLOWXTAL 2'h2
`define REF_EXTIN 2'h3
`define HZ_FRO12 32'd12000000
`define HZ_INT16 32'd16000000
`define HZ_SLOWXTAL 32'd32768
`define SYS_REF_MIN_HZ 32'd32768
`define AUD_REF_MIN_HZ 32'd1000000
`define REF_MAX_HZ 32'd25000000
// Low power modes per processor
`define MODE_ACT 2'h0
`define MODE_SLEEP 2'h1
`define MODE_DSLEEP 2'h2
`define MODE_DPD 2'h3
// Field positions
`define F_FAST60 3
`define F_SYSEN 0
`define F_AUDEN 1
`define F_SYSREF 2
`define F_AUDREF 4
`define F_ANA 8
`define F_WDEN 0
`define F_OSCKEEP 4
`define F_ANAKEEP 10
// Timing: lock time in us, clock in MHz, reset pulse after power-down
`define SYNTH_LOCK_US 150
`define CLK_MHZ 20
`define RST_CYCLES 4'hF
// Reset values
`define RV_ZERO 32'h0000_0000
`define RV_RAMOFF 30'h0000_0000
`define RV_PCLK 32'hFFFF_FFFF
`endif

//--- pmc_monitor.sv
// Concurrent checks on the power mode and clock control ports
`timescale 1ns/1ps
module pmc_monitor (
  // Clock and reset
  input wire clk_sys,
  input wire resetn,
  // Bus answer
  input wire hreadyout,
  input wire hresp,
  // Processor and wake side
  input wire [1:0] cpuWfi,
  input wire [1:0] cpuIrq,
  input wire one_hz_alarm_flag,
  // Clock and power outputs
  input wire [2:0] mainClkSel,
  input wire mainClkEn,
  input wire [1:0] cpuClkEn,
  input wire [31:0] periphClkEn,
  input wire [5:0] oscEn,
  input wire sysSynthEn,
  input wire sysSynthLocked,
  input wire audSynthEn,
  input wire corePowerEn,
  input wire coreResetN,
  input wire pinHighZ,
  input wire rtcWakeReq,
  input wire wdogEnable,
  input wire [30:0] wdogCfg
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////
  // Wake of a sleeping processor 0 takes a few edges, never more
  sequence s_irqAsleep;
    mainClkEn && !cpuClkEn[0] && cpuIrq[0];
  endsequence
  sequence s_resume;
    ##[1:3] cpuClkEn[0];
  endsequence
  a_ahb_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not zero wait OKAY");
  a_sleep_entry: assert property ($fell(cpuClkEn[0]) |-> $past(cpuWfi[0]))
    else $error("processor clock stopped without idle wait");
  a_wake_resume: assert property (s_irqAsleep |-> s_resume)
    else $error("processor clock not back after interrupt");
  a_dsleep_gate: assert property (!mainClkEn |-> periphClkEn == 32'h0
    && !sysSynthEn && !audSynthEn) else $error("clocks alive in deep sleep");
  a_lock_wait: assert property ($rose(sysSynthEn) |-> !sysSynthLocked[*8])
    else $error("synthesizer locked too soon");
  a_sel_locked: assert property (mainClkSel == 3'h4 |-> sysSynthLocked)
    else $error("unlocked synthesizer used as main clock");
  a_wdog_lock: assert property (wdogEnable && coreResetN |=> !coreResetN
    || (wdogEnable && $stable(wdogCfg))) else $error("watchdog changed");
  a_pd_off: assert property (pinHighZ |-> !corePowerEn && oscEn == 6'h00)
    else $error("power still on in power down");
  a_rtc_wake: assert property ($rose(one_hz_alarm_flag) |=> rtcWakeReq)
    else $error("alarm did not raise wake request");
  a_core_reset: assert property ($fell(coreResetN) |-> !coreResetN[*8])
    else $error("core reset too short");
  a_reset_clock: assert property (!coreResetN && !$past(coreResetN)
    |-> mainClkSel == 3'h0 && !wdogEnable) else $error("core reset not clean");
endmodule // pmc_monitor
bind power_mode_clock_control pmc_monitor mon (.clk_sys(clk_sys),
  .resetn(resetn), .hreadyout(hreadyout), .hresp(hresp), .cpuWfi(cpuWfi),
  .cpuIrq(cpuIrq), .one_hz_alarm_flag(one_hz_alarm_flag),
  .mainClkSel(mainClkSel), .mainClkEn(mainClkEn), .cpuClkEn(cpuClkEn),
  .periphClkEn(periphClkEn), .oscEn(oscEn), .sysSynthEn(sysSynthEn),
  .sysSynthLocked(sysSynthLocked), .audSynthEn(audSynthEn),
  .corePowerEn(corePowerEn), .coreResetN(coreResetN), .pinHighZ(pinHighZ),
  .rtcWakeReq(rtcWakeReq), .wdogEnable(wdogEnable), .wdogCfg(wdogCfg));

//--- core_partner.sv
// Behavioural model of the two processor cores and the wake sources
`timescale 1ns/1ps
module core_partner (
  // Clock and reset
  input wire clk_sys,
  input wire resetn,
  // Commands from the bench
  input wire [1:0] idleCmd,
  input wire [1:0] irqCmd,
  input wire [9:0] srcCmd,
  input wire coreResetN,
  // Towards the block
  output reg [1:0] cpuWfi,
  output reg [1:0] cpuIrq,
  output reg [7:0] wakeReq,
  output reg one_hz_alarm_flag,
  output reg power_manager_irq_pin_n
);
  // A core idles when told and stays idle until interrupted or reset
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cpuWfi <= 2'h0;
      cpuIrq <= 2'h0;
      wakeReq <= 8'h00;
      one_hz_alarm_flag <= 1'b0;
      power_manager_irq_pin_n <= 1'b1;
    end else begin
      cpuWfi <= coreResetN ? ((cpuWfi | idleCmd) & ~cpuIrq) : 2'h0;
      cpuIrq <= irqCmd;
      wakeReq <= srcCmd[7:0];
      one_hz_alarm_flag <= srcCmd[8];
      power_manager_irq_pin_n <= !srcCmd[9]; // Pin is active low
    end
  end
endmodule // core_partner

//--- testbench.sv
// Self-checking testbench for the power mode and clock control block
`timescale 1ns/1ps
`include "pmc_defs.vh"
module testbench;
  reg clk_sys, resetn, hsel, hwrite, rdPhase;
  reg [31:0] haddr, hwdata, rA, rB, lfsr;
  reg [1:0] htrans, idleCmd, irqCmd;
  reg [9:0] srcCmd;
  wire hreadyout, hresp, fastOsc60, mainClkEn, sysSynthEn, sysSynthLocked;
  wire audSynthEn, corePowerEn, coreResetN, pinHighZ, rtcWakeReq, wdogEnable;
  wire alarm, pmicN;
  wire [31:0] hrdata, periphClkEn;
  wire [2:0] mainClkSel;
  wire [1:0] cpuClkEn, cpuWfi, cpuIrq;
  wire [5:0] oscEn;
  wire [3:0] analogPwrEn;
  wire [29:0] ramPowerOff;
  wire [30:0] wdogCfg;
  wire [7:0] wakeReq;
  int error_cnt = 0;
  int checks_done = 0;
  int k;
  logic [31:0] expQ[$];
  power_mode_clock_control dut (.clk_sys(clk_sys), .resetn(resetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .cpuWfi(cpuWfi), .cpuIrq(cpuIrq),
    .wakeReq(wakeReq), .one_hz_alarm_flag(alarm),
    .power_manager_irq_pin_n(pmicN), .mainClkSel(mainClkSel),
    .fastOsc60(fastOsc60), .mainClkEn(mainClkEn), .cpuClkEn(cpuClkEn),
    .periphClkEn(periphClkEn), .oscEn(oscEn), .sysSynthEn(sysSynthEn),
    .sysSynthLocked(sysSynthLocked), .audSynthEn(audSynthEn),
    .analogPwrEn(analogPwrEn), .ramPowerOff(ramPowerOff),
    .corePowerEn(corePowerEn), .coreResetN(coreResetN), .pinHighZ(pinHighZ),
    .rtcWakeReq(rtcWakeReq), .wdogEnable(wdogEnable), .wdogCfg(wdogCfg));
  core_partner cores (.clk_sys(clk_sys), .resetn(resetn), .idleCmd(idleCmd),
    .irqCmd(irqCmd), .srcCmd(srcCmd), .coreResetN(coreResetN),
    .cpuWfi(cpuWfi), .cpuIrq(cpuIrq), .wakeReq(wakeReq),
    .one_hz_alarm_flag(alarm), .power_manager_irq_pin_n(pmicN));
  ////////////////////////////////////////////////////////////////////////////
  // Clock of 50 ns
  always #25 clk_sys = ~clk_sys;
  function logic [31:0] lfsrNext(input logic [31:0] s);
    lfsrNext = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task check(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // One single transfer; a read notes its expected word for the watcher
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    rdPhase <= !w;
    if (!w) expQ.push_back(d);
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rdPhase <= 1'b0;
  endtask
  // One-cycle idle and interrupt pulses, level wake sources, to the partner; settles long enough for the response
  task cmd(input logic [1:0] idle, input logic [1:0] irq, input logic [9:0] s);
    @(posedge clk_sys);
    idleCmd <= idle;
    irqCmd <= irq;
    srcCmd <= s;
    @(posedge clk_sys);
    idleCmd <= 2'h0;
    irqCmd <= 2'h0;
    settle(6);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Read data is taken at the edge that ends its data phase
  always @(posedge clk_sys) begin : rdWatch
    logic [31:0] e;
    if (rdPhase && hreadyout === 1'b1) begin
      e = expQ.pop_front();
      check("hrdata", e, hrdata);
    end
  end
  // Hang guard, well beyond the synthesizer lock wait
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    wrap_up;
  end
  initial begin
    clk_sys = 0; resetn = 0; hsel = 0; hwrite = 0; rdPhase = 0;
    haddr = 0; hwdata = 0; htrans = 0; idleCmd = 0; irqCmd = 0; srcCmd = 0;
    lfsr = 32'hEA2DDE36;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    settle(2);
    check("mainClkSel", 3'h0, mainClkSel);
    check("oscEn", 6'h3F, oscEn);
    ahb(0, `A_PCLK, 32'hFFFF_FFFF);
    ahb(0, 8'h20, 32'h0);
    $display("reset test done");
    for (k = 0; k < 2; k++) begin
      ahb(1, `A_CLKSEL, {28'h0, k[0], 3'h1});
      settle(3);
      check("mainClkSel", 3'h1, mainClkSel);
      check("fastOsc60", k[0], fastOsc60);
    end
    $display("fast oscillator test done");
    ahb(1, `A_SYNTH, 32'h0000_0F13);
    ahb(1, `A_CLKSEL, 32'h4);
    settle(3);
    check("audSynthEn", 1'b1, audSynthEn);
    check("analogPwrEn", 4'hF, analogPwrEn);
    check("mainClkSel", 3'h0, mainClkSel);
    check("sysSynthLocked", 1'b0, sysSynthLocked);
    settle(3000);
    check("sysSynthLocked", 1'b1, sysSynthLocked);
    check("mainClkSel", 3'h4, mainClkSel);
    ahb(1, `A_SYNTH, 32'h0000_0F23);
    settle(3);
    check("audSynthEn", 1'b0, audSynthEn);
    check("sysSynthEn", 1'b1, sysSynthEn);
    $display("synthesizer test done");
    ahb(1, `A_WDOG, 32'h1234_5679);
    ahb(1, `A_WDOG, 32'h0);
    ahb(0, `A_WDOG, 32'h1234_5679);
    settle(3);
    check("wdogCfg", 31'h091A_2B3C, wdogCfg);
    $display("watchdog test done");
    rA = lfsrNext(lfsr);
    rB = lfsrNext(rA);
    ahb(1, `A_RAMOFF, rA);
    ahb(1, `A_PCLK, rB);
    settle(3);
    check("ramPowerOff", rA[29:0], ramPowerOff);
    check("periphClkEn", rB, periphClkEn);
    ahb(1, `A_LPCFG, 32'h1);
    cmd(2'h1, 2'h0, 10'h0);
    check("cpuClkEn", 2'h2, cpuClkEn);
    check("periphClkEn", rB, periphClkEn);
    cmd(2'h0, 2'h1, 10'h0);
    check("cpuClkEn", 2'h3, cpuClkEn);
    $display("sleep test done");
    ahb(1, `A_WAKEEN, 32'h4);
    ahb(1, `A_LPCFG, 32'h56);
    cmd(2'h3, 2'h0, 10'h0);
    check("mainClkEn", 1'b0, mainClkEn);
    check("oscEn", 6'h05, oscEn);
    check("analogPwrEn", 4'h0, analogPwrEn);
    check("sysSynthEn", 1'b0, sysSynthEn);
    check("ramPowerOff", rA[29:0], ramPowerOff);
    cmd(2'h0, 2'h0, 10'h004);
    check("mainClkEn", 1'b1, mainClkEn);
    cmd(2'h0, 2'h3, 10'h0);
    check("cpuClkEn", 2'h3, cpuClkEn);
    $display("deep sleep test done");
    for (k = 0; k < 2; k++) begin
      ahb(1, `A_LPCFG, 32'h7);
      cmd(2'h3, 2'h0, 10'h0);
      check("pinHighZ", 1'b1, pinHighZ);
      check("corePowerEn", 1'b0, corePowerEn);
      cmd(2'h0, 2'h0, k ? 10'h200 : 10'h100);
      if (k == 0) check("rtcWakeReq", 1'b1, rtcWakeReq);
      settle(20);
      check("coreResetN", 1'b1, coreResetN);
      check("pinHighZ", 1'b0, pinHighZ);
      check("mainClkSel", 3'h0, mainClkSel);
      cmd(2'h0, 2'h0, 10'h0);
      ahb(0, `A_RAMOFF, 32'h0);
    end
    $display("power down test done");
    settle(2);
    wrap_up;
  end
endmodule // testbench
